// ### core/rcb_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcb_params.svh"
module rcb_bank (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // Register port
   input  wire logic [15:0] i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [15:0]      o_rdata,
   // Sequencer timeslot pulses
   input  wire logic        i_seq_up,
   input  wire logic        i_seq_down,
   input  wire logic [2:0]  i_seq_slot,
   // Hardware enable inputs
   input  wire logic        i_hw_en1,
   input  wire logic        i_hw_en2,
   // Undervoltage events
   input  wire logic        i_uv_b,
   input  wire logic        i_uv_c,
   // Channel A sleep settings
   output logic [2:0]       o_chan_a_sleep_slot,
   output logic             o_chan_a_sleep_opmode,
   output logic [4:0]       o_chan_a_sleep_volt,
   // Channel B drive
   output logic             o_chan_b_en,
   output logic [11:0]      o_chan_b_mv,
   output logic             o_chan_b_lowpwr,
   output logic             o_chan_b_discharge,
   output logic             o_chan_b_switch_sel,
   // Channel C drive
   output logic             o_chan_c_en,
   output logic [11:0]      o_chan_c_mv,
   output logic             o_chan_c_lowpwr,
   output logic             o_chan_c_discharge,
   output logic             o_chan_c_switch_sel,
   // Device reset request and interrupt
   output logic             o_dev_reset_req,
   output logic             o_irq
);

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   rcb_pkg::rcb_top_state_type s_q, s_d;
   rcb_chan_if                 b_if ();
   rcb_chan_if                 c_if ();
   logic [`RCB_IRQ_W-1:0]      irq_status;
   logic [`RCB_IRQ_W-1:0]      irq_enable;
   logic                       irq_clr_wr;
   logic                       irq_en_wr;

   // Masked store: undefined bits never reach a flip-flop
   function automatic logic [15:0] masked(input logic [15:0] data,
                                          input logic [15:0] mask);
      return data & mask;
   endfunction

   // Address match used by the interrupt clear and enable write decode
   function automatic logic hit(input logic [15:0] addr,
                                input logic [15:0] target);
      return addr == target;
   endfunction

   // -------------------------------------------------------------------
   // Register file
   // -------------------------------------------------------------------

   // Writes store, reads answer one cycle later, else data is zero
   always_comb begin
      s_d         = s_q;
      s_d.rdata   = 16'h0000;
      s_d.rst_req = b_if.rst_req | c_if.rst_req;
      if (i_wr) begin
         case (i_addr)
            `RCB_ADDR_A_SLP: s_d.a_slp = masked(i_wdata, `RCB_SLP_MASK);
            `RCB_ADDR_B_CTL: s_d.b_ctl = masked(i_wdata, `RCB_CTL_MASK);
            `RCB_ADDR_B_ON:  s_d.b_on  = masked(i_wdata, `RCB_ON_MASK);
            `RCB_ADDR_B_SLP: s_d.b_slp = masked(i_wdata, `RCB_SLP_MASK);
            `RCB_ADDR_C_CTL: s_d.c_ctl = masked(i_wdata, `RCB_CTL_MASK);
            `RCB_ADDR_C_ON:  s_d.c_on  = masked(i_wdata, `RCB_ON_MASK);
            `RCB_ADDR_C_SLP: s_d.c_slp = masked(i_wdata, `RCB_SLP_MASK);
            default:         s_d.a_slp = s_d.a_slp;
         endcase
      end
      if (i_rd) begin
         case (i_addr)
            `RCB_ADDR_A_SLP:    s_d.rdata = s_q.a_slp;
            `RCB_ADDR_B_CTL:    s_d.rdata = s_q.b_ctl;
            `RCB_ADDR_B_ON:     s_d.rdata = s_q.b_on;
            `RCB_ADDR_B_SLP:    s_d.rdata = s_q.b_slp;
            `RCB_ADDR_C_CTL:    s_d.rdata = s_q.c_ctl;
            `RCB_ADDR_C_ON:     s_d.rdata = s_q.c_on;
            `RCB_ADDR_C_SLP:    s_d.rdata = s_q.c_slp;
            `RCB_ADDR_IRQ_STAT: s_d.rdata = {14'h0000, irq_status};
            `RCB_ADDR_IRQ_EN:   s_d.rdata = {14'h0000, irq_enable};
            default:            s_d.rdata = 16'h0000;
         endcase
      end
   end

   // State register with documented reset values
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         s_q.a_slp   <= `RCB_SLP_RST;
         s_q.b_ctl   <= `RCB_CTL_RST;
         s_q.b_on    <= `RCB_ON_RST;
         s_q.b_slp   <= `RCB_SLP_RST;
         s_q.c_ctl   <= `RCB_CTL_RST;
         s_q.c_on    <= `RCB_ON_RST;
         s_q.c_slp   <= `RCB_SLP_RST;
         s_q.rdata   <= 16'h0000;
         s_q.rst_req <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // -------------------------------------------------------------------
   // Channel logic
   // -------------------------------------------------------------------

   // Configuration words handed to the channels
   assign b_if.ctl = s_q.b_ctl;
   assign b_if.on  = s_q.b_on;
   assign b_if.slp = s_q.b_slp;
   assign c_if.ctl = s_q.c_ctl;
   assign c_if.on  = s_q.c_on;
   assign c_if.slp = s_q.c_slp;

   // Channel B
   rcb_chan u_chan_b (
      .i_clk      (i_clk),
      .i_sys_rst  (i_sys_rst),
      .i_seq_up   (i_seq_up),
      .i_seq_down (i_seq_down),
      .i_seq_slot (i_seq_slot),
      .i_hw_en1   (i_hw_en1),
      .i_hw_en2   (i_hw_en2),
      .i_uv       (i_uv_b),
      .cif        (b_if.chan)
   );

   // Channel C
   rcb_chan u_chan_c (
      .i_clk      (i_clk),
      .i_sys_rst  (i_sys_rst),
      .i_seq_up   (i_seq_up),
      .i_seq_down (i_seq_down),
      .i_seq_slot (i_seq_slot),
      .i_hw_en1   (i_hw_en1),
      .i_hw_en2   (i_hw_en2),
      .i_uv       (i_uv_c),
      .cif        (c_if.chan)
   );

   // -------------------------------------------------------------------
   // Interrupts
   // -------------------------------------------------------------------

   // Clear register is write-only, so it never answers a read
   assign irq_clr_wr = i_wr && hit(i_addr, `RCB_ADDR_IRQ_CLR);
   assign irq_en_wr  = i_wr && hit(i_addr, `RCB_ADDR_IRQ_EN);

   // Undervoltage flags regardless of the fault action
   rcb_irq u_irq (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_evt     ({i_uv_c, i_uv_b}),
      .i_clr_wr  (irq_clr_wr),
      .i_en_wr   (irq_en_wr),
      .i_wdata   (i_wdata[`RCB_IRQ_W-1:0]),
      .o_status  (irq_status),
      .o_enable  (irq_enable),
      .o_irq     (o_irq)
   );

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------

   // Register port and channel A straight from the register flops
   assign o_rdata               = s_q.rdata;
   assign o_chan_a_sleep_slot   = s_q.a_slp[`RCB_SLOT_HI:`RCB_SLOT_LO];
   assign o_chan_a_sleep_opmode = s_q.a_slp[`RCB_MODE_BIT];
   assign o_chan_a_sleep_volt   = s_q.a_slp[`RCB_VOLT_HI:`RCB_VOLT_LO];
   assign o_dev_reset_req       = s_q.rst_req;

   // Channel drive comes from the channel state flops
   assign o_chan_b_en         = b_if.en;
   assign o_chan_b_mv         = b_if.mv;
   assign o_chan_b_lowpwr     = b_if.lowpwr;
   assign o_chan_b_discharge  = b_if.discharge;
   assign o_chan_b_switch_sel = b_if.switch_sel;
   assign o_chan_c_en         = c_if.en;
   assign o_chan_c_mv         = c_if.mv;
   assign o_chan_c_lowpwr     = c_if.lowpwr;
   assign o_chan_c_discharge  = c_if.discharge;
   assign o_chan_c_switch_sel = c_if.switch_sel;

endmodule // rcb_bank
`default_nettype wire

// ### core/rcb_chan.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcb_params.svh"
module rcb_chan (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   // Sequencer timeslot pulses
   input  wire logic       i_seq_up,
   input  wire logic       i_seq_down,
   input  wire logic [2:0] i_seq_slot,
   // Hardware enable inputs and fault
   input  wire logic       i_hw_en1,
   input  wire logic       i_hw_en2,
   input  wire logic       i_uv,
   // Configuration and drive
   rcb_chan_if.chan        cif
);
   rcb_pkg::rcb_chan_state_type s_q, s_d;

   // ----------------------------------------------------------------
   // Sequencing, hardware control and fault action
   // ----------------------------------------------------------------
   always_comb begin
      logic [2:0] on_code;
      logic [2:0] slp_code;
      logic       hw_assigned;
      logic       hw_in;
      logic       hwc_act;
      logic       on_en;
      logic [4:0] volt;
      logic       lp;
      on_en    = 1'b0;
      hwc_act  = 1'b0;
      volt     = 5'h00;
      lp       = 1'b0;
      on_code  = cif.on[`RCB_SLOT_HI:`RCB_SLOT_LO];
      slp_code = cif.slp[`RCB_SLOT_HI:`RCB_SLOT_LO];
      hw_assigned = (on_code == 3'h6) || (on_code == 3'h7);
      hw_in    = (on_code == 3'h7) ? i_hw_en2 : i_hw_en1;
      s_d = s_q;
      s_d.rst_req = 1'b0;
      // Start-up: code 000 never enables
      if (i_seq_up) begin
         if (!hw_assigned && on_code != 3'h0 && i_seq_slot == on_code) begin
            s_d.phase     = rcb_pkg::RCB_PH_ON;
            s_d.fault_off = 1'b0;
         end
         if (hw_assigned && i_seq_slot == 3'h1) begin
            s_d.phase     = rcb_pkg::RCB_PH_ON;
            s_d.fault_off = 1'b0;
         end
      end
      // Sleep or shutdown entry, only from the ON phase
      if (i_seq_down && s_q.phase == rcb_pkg::RCB_PH_ON) begin
         unique case (slp_code)
            3'h0: if (i_seq_slot == 3'h5) s_d.phase = rcb_pkg::RCB_PH_SLEEP;
            3'h6: if (i_seq_slot == 3'h3) s_d.phase = rcb_pkg::RCB_PH_SLEEP;
            3'h7: if (i_seq_slot == 3'h1) s_d.phase = rcb_pkg::RCB_PH_SLEEP;
            default: begin
               if (i_seq_slot == 3'(3'h6 - slp_code)) begin
                  s_d.phase = hw_assigned ? rcb_pkg::RCB_PH_SLEEP
                                          : rcb_pkg::RCB_PH_OFF;
               end
            end
         endcase
      end
      // Undervoltage: reserved code 11 does nothing
      if (i_uv) begin
         unique case (cif.ctl[`RCB_ACT_HI:`RCB_ACT_LO])
            2'h1:    s_d.fault_off = 1'b1;
            2'h2:    s_d.rst_req   = 1'b1;
            default: s_d.fault_off = s_d.fault_off;
         endcase
      end
      // Drive settings of the present phase
      on_en = (s_q.phase != rcb_pkg::RCB_PH_OFF) && !s_q.fault_off
              && (!hw_assigned || hw_in);
      if (s_q.phase == rcb_pkg::RCB_PH_SLEEP) begin
         volt = cif.slp[`RCB_VOLT_HI:`RCB_VOLT_LO];
         lp   = cif.slp[`RCB_MODE_BIT];
      end else begin
         volt = cif.on[`RCB_VOLT_HI:`RCB_VOLT_LO];
         lp   = cif.on[`RCB_MODE_BIT];
      end
      hwc_act = (cif.ctl[`RCB_SRC_LO] & i_hw_en1)
                | (cif.ctl[`RCB_SRC_HI] & i_hw_en2);
      if (hwc_act) begin
         volt = cif.ctl[`RCB_PICK_BIT] ? cif.slp[`RCB_VOLT_HI:`RCB_VOLT_LO]
                                       : cif.on[`RCB_VOLT_HI:`RCB_VOLT_LO];
         unique case (cif.ctl[`RCB_HWM_HI:`RCB_HWM_LO])
            2'h1:    on_en = 1'b0;
            2'h3:    lp    = cif.on[`RCB_MODE_BIT];
            default: lp    = 1'b1;
         endcase
      end
      s_d.en         = on_en;
      s_d.mv         = rcb_pkg::rcb_volt_mv(volt);
      s_d.lowpwr     = lp;
      s_d.discharge  = !on_en && !cif.ctl[`RCB_FLT_BIT];
      s_d.switch_sel = cif.ctl[`RCB_SWI_BIT];
   end

   // State register; disabled and discharging after reset
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         s_q <= '{phase: rcb_pkg::RCB_PH_OFF, fault_off: 1'b0, en: 1'b0,
                  mv: `RCB_V_BASE_LO, lowpwr: 1'b0, discharge: 1'b1,
                  switch_sel: 1'b0, rst_req: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign cif.en         = s_q.en;
   assign cif.mv         = s_q.mv;
   assign cif.lowpwr     = s_q.lowpwr;
   assign cif.discharge  = s_q.discharge;
   assign cif.switch_sel = s_q.switch_sel;
   assign cif.rst_req    = s_q.rst_req;
endmodule // rcb_chan
`default_nettype wire

// ### core/rcb_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcb_params.svh"
module rcb_irq (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_sys_rst,
   // Events and software access
   input  wire logic [`RCB_IRQ_W-1:0] i_evt,
   input  wire logic                  i_clr_wr,
   input  wire logic                  i_en_wr,
   input  wire logic [`RCB_IRQ_W-1:0] i_wdata,
   // Status and interrupt
   output logic [`RCB_IRQ_W-1:0]      o_status,
   output logic [`RCB_IRQ_W-1:0]      o_enable,
   output logic                       o_irq
);
   rcb_pkg::rcb_irq_state_type s_q, s_d;

   // Sticky status; a new event beats a clear in the same cycle
   always_comb begin
      s_d = s_q;
      if (i_en_wr) begin
         s_d.enable = i_wdata;
      end
      if (i_clr_wr) begin
         s_d.status = s_q.status & ~i_wdata;
      end
      s_d.status = s_d.status | i_evt;
      s_d.irq    = |(s_d.status & s_d.enable);
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_status = s_q.status;
   assign o_enable = s_q.enable;
   assign o_irq    = s_q.irq;
endmodule // rcb_irq
`default_nettype wire

// ### inc/rcb_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
// Configuration words down to a channel, its drive state back up
interface rcb_chan_if;
   logic [15:0] ctl;
   logic [15:0] on;
   logic [15:0] slp;
   logic        en;
   logic [11:0] mv;
   logic        lowpwr;
   logic        discharge;
   logic        switch_sel;
   logic        rst_req;
   modport bank (output ctl, on, slp,
                 input  en, mv, lowpwr, discharge, switch_sel, rst_req);
   modport chan (input  ctl, on, slp,
                 output en, mv, lowpwr, discharge, switch_sel, rst_req);
endinterface // rcb_chan_if
`default_nettype wire

// ### inc/rcb_params.svh
`ifndef RCB_PARAMS_SVH
`define RCB_PARAMS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define RCB_ADDR_A_SLP     16'h407c
`define RCB_ADDR_B_CTL     16'h407d
`define RCB_ADDR_B_ON      16'h407e
`define RCB_ADDR_B_SLP     16'h407f
`define RCB_ADDR_C_CTL     16'h4080
`define RCB_ADDR_C_ON      16'h4081
`define RCB_ADDR_C_SLP     16'h4082
`define RCB_ADDR_IRQ_STAT  16'h40a0
`define RCB_ADDR_IRQ_CLR   16'h40a1
`define RCB_ADDR_IRQ_EN    16'h40a2

// ----------------------------------------------------------------------
// Writable bit masks and reset values
// ----------------------------------------------------------------------
`define RCB_SLP_MASK       16'he11f
`define RCB_ON_MASK        16'he11f
`define RCB_CTL_MASK       16'hdfc0
`define RCB_SLP_RST        16'h0100
`define RCB_ON_RST         16'h0000
`define RCB_CTL_RST        16'h0200
`define RCB_IRQ_RST        2'h0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RCB_SLOT_HI        15
`define RCB_SLOT_LO        13
`define RCB_MODE_BIT       8
`define RCB_VOLT_HI        4
`define RCB_VOLT_LO        0
`define RCB_ACT_HI         15
`define RCB_ACT_LO         14
`define RCB_SRC_HI         12
`define RCB_SRC_LO         11
`define RCB_PICK_BIT       10
`define RCB_HWM_HI         9
`define RCB_HWM_LO         8
`define RCB_FLT_BIT        7
`define RCB_SWI_BIT        6
`define RCB_IRQ_W          2

// ----------------------------------------------------------------------
// Voltage code mapping, millivolts
// ----------------------------------------------------------------------
`define RCB_VBREAK         5'h0c
`define RCB_V_FIRST_HI     5'h0d
`define RCB_V_BASE_LO      12'h3e8
`define RCB_V_STEP_LO      12'h032
`define RCB_V_BASE_HI      12'h6a4
`define RCB_V_STEP_HI      12'h064

`endif

// ### inc/rcb_pkg.sv
`include "rcb_params.svh"
package rcb_pkg;
   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      RCB_PH_OFF   = 2'b00,
      RCB_PH_ON    = 2'b01,
      RCB_PH_SLEEP = 2'b10
   } rcb_phase_type;

   typedef struct packed {
      rcb_phase_type phase;
      logic          fault_off;
      logic          en;
      logic [11:0]   mv;
      logic          lowpwr;
      logic          discharge;
      logic          switch_sel;
      logic          rst_req;
   } rcb_chan_state_type;

   typedef struct packed {
      logic [`RCB_IRQ_W-1:0] status;
      logic [`RCB_IRQ_W-1:0] enable;
      logic                  irq;
   } rcb_irq_state_type;

   typedef struct packed {
      logic [15:0] a_slp;
      logic [15:0] b_ctl;
      logic [15:0] b_on;
      logic [15:0] b_slp;
      logic [15:0] c_ctl;
      logic [15:0] c_on;
      logic [15:0] c_slp;
      logic [15:0] rdata;
      logic        rst_req;
   } rcb_top_state_type;

   // Voltage code to millivolts, two linear segments
   function automatic logic [11:0] rcb_volt_mv(input logic [4:0] code);
      logic [4:0] hi_idx;
      hi_idx = code - `RCB_V_FIRST_HI;
      if (code <= `RCB_VBREAK) begin
         return `RCB_V_BASE_LO + ({7'h00, code} * `RCB_V_STEP_LO);
      end
      return `RCB_V_BASE_HI + ({7'h00, hi_idx} * `RCB_V_STEP_HI);
   endfunction
endpackage

// ### testbench/rcb_bank_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcb_params.svh"
// ------------------------------------------------------------
// Port checks of the control bank
// ------------------------------------------------------------
module rcb_bank_asserts (
   // Clock and reset
   input wire logic        i_clk,
   input wire logic        i_sys_rst,
   // Register port and events
   input wire logic [15:0] i_addr,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [15:0] o_rdata,
   input wire logic [15:0] i_wdata,
   input wire logic        i_uv_b,
   input wire logic        i_uv_c,
   // Drive outputs
   input wire logic [2:0]  o_chan_a_sleep_slot,
   input wire logic        o_chan_a_sleep_opmode,
   input wire logic [4:0]  o_chan_a_sleep_volt,
   input wire logic        o_chan_b_en,
   input wire logic        o_chan_b_discharge,
   input wire logic [11:0] o_chan_b_mv,
   input wire logic        o_chan_c_en,
   input wire logic        o_chan_c_discharge,
   input wire logic        o_dev_reset_req,
   input wire logic        o_irq
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // Decodes; irq words sit apart from the channel words
   logic       in_bank;
   logic       is_ctl;
   logic       is_irq;
   logic [8:0] a_out;
   assign in_bank = i_addr >= `RCB_ADDR_A_SLP && i_addr <= `RCB_ADDR_C_SLP;
   assign is_ctl = i_addr == `RCB_ADDR_B_CTL || i_addr == `RCB_ADDR_C_CTL;
   assign is_irq = i_addr >= `RCB_ADDR_IRQ_STAT && i_addr <= `RCB_ADDR_IRQ_EN;
   assign a_out = {o_chan_a_sleep_slot, o_chan_a_sleep_opmode,
                   o_chan_a_sleep_volt};
   unmapped_read_a: assert property (i_rd && !in_bank && !is_irq
      |=> o_rdata == 16'h0000) else $error("unmapped read not zero");
   ctl_mask_a: assert property (i_rd && is_ctl
      |=> (o_rdata & ~`RCB_CTL_MASK) == 16'h0000) else $error("ctl bits");
   word_mask_a: assert property (i_rd && in_bank && !is_ctl
      |=> (o_rdata & ~`RCB_ON_MASK) == 16'h0000) else $error("word bits");
   irq_rise_a: assert property ($rose(o_irq) |-> $past(i_uv_b)
      || $past(i_uv_c) || $past(i_wr)) else $error("irq rose alone");
   irq_fall_a: assert property ($fell(o_irq) |-> $past(i_wr)
      && ($past(i_addr) == `RCB_ADDR_IRQ_CLR
          || $past(i_addr) == `RCB_ADDR_IRQ_EN)) else $error("irq fell alone");
   reset_cause_a: assert property (o_dev_reset_req
      |-> $past(i_uv_b, 2) || $past(i_uv_c, 2)) else $error("reset cause");
   reset_pulse_a: assert property (o_dev_reset_req
      |=> !o_dev_reset_req) else $error("reset pulse long");
   chan_a_follow_a: assert property (i_wr && i_addr == `RCB_ADDR_A_SLP
      |-> ##2 a_out == $past({i_wdata[15:13], i_wdata[8], i_wdata[4:0]}, 2))
      else $error("chan a fields");
   chan_a_hold_a: assert property ($changed(a_out)
      |-> $past(i_wr && i_addr == `RCB_ADDR_A_SLP)) else $error("a moved");
   discharge_a: assert property (!(o_chan_b_en && o_chan_b_discharge)
      && !(o_chan_c_en && o_chan_c_discharge)) else $error("discharge on");
   mv_range_a: assert property (o_chan_b_mv >= 12'h3e8
      && o_chan_b_mv <= 12'hdac) else $error("mv range");
endmodule // rcb_bank_asserts
bind rcb_bank rcb_bank_asserts rcb_bank_asserts_inst (.*);
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcb_params.svh"
module testbench;
   // ---------------------------------------------------------
   // Stimulus, outputs, tables
   // ---------------------------------------------------------
   logic i_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
   logic i_seq_up = 1'b0, i_seq_down = 1'b0, i_uv_b = 1'b0, i_uv_c = 1'b0;
   logic i_hw_en1 = 1'b0, i_hw_en2 = 1'b0, o_irq, o_dev_reset_req;
   logic [15:0] i_addr = 16'h0000, i_wdata = 16'h0000, o_rdata, b_st, c_st;
   logic [2:0]  i_seq_slot = 3'h0, o_chan_a_sleep_slot;
   logic [4:0]  o_chan_a_sleep_volt;
   logic [11:0] o_chan_b_mv, o_chan_c_mv, mv;
   logic o_chan_a_sleep_opmode, o_chan_b_en, o_chan_b_lowpwr;
   logic o_chan_b_discharge, o_chan_b_switch_sel, o_chan_c_en;
   logic o_chan_c_lowpwr, o_chan_c_discharge, o_chan_c_switch_sel;
   int mismatches = 0, n_checks = 0, rst_pulses = 0;
   logic [15:0] rv [7] = '{16'h0100, 16'h0200, 16'h0000, 16'h0100,
                           16'h0200, 16'h0000, 16'h0100};
   logic [15:0] mk [7] = '{16'he11f, 16'hdfc0, 16'he11f, 16'he11f,
                           16'hdfc0, 16'he11f, 16'he11f};
   logic [15:0] ks [3] = '{16'h001f, 16'hc10d, 16'he10c};
   logic [15:0] ke [3] = '{16'h8dac, 16'hc6a4, 16'hc640};
   logic [2:0]  kt [3] = '{3'h5, 3'h3, 3'h1};
   logic [15:0] hc [7] = '{16'h0c00, 16'h0940, 16'h1600, 16'h1e00,
                           16'h1b40, 16'h0d80, 16'h0400};
   logic [15:0] he [7] = '{16'hcdac, 16'h3000, 16'h84e2, 16'hcdac,
                           16'h94e2, 16'h0000, 16'h84e2};
   logic [15:0] hm [7] = '{16'hffff, 16'hb000, 16'hffff, 16'hffff,
                           16'hffff, 16'hb000, 16'hffff};
   logic [1:0]  hi [7] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h3};
   // Packed view: en, low power, discharge, switch, millivolts
   assign b_st = {o_chan_b_en, o_chan_b_lowpwr, o_chan_b_discharge,
                  o_chan_b_switch_sel, o_chan_b_mv};
   assign c_st = {o_chan_c_en, o_chan_c_lowpwr, o_chan_c_discharge,
                  o_chan_c_switch_sel, o_chan_c_mv};
   rcb_bank rcb_bank_inst (.*);
   // Clock and reset-request counter
   always #10 i_clk = ~i_clk;
   always @(posedge i_clk) if (o_dev_reset_req === 1'b1) rst_pulses++;
   // ---------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Two edges cover register-to-output and phase-to-output delay
   task automatic settle;
      repeat (2) @(posedge i_clk);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, d);
      @(posedge i_clk);
      {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
      @(posedge i_clk);
      i_wr <= 1'b0;
      settle();
   endtask
   task automatic rd(input logic [15:0] a, exp);
      @(posedge i_clk);
      {i_rd, i_addr} <= {1'b1, a};
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk("rdata", o_rdata, exp);
   endtask
   // Bits: start-up slot, sleep slot, fault B, fault C
   task automatic pulse(input logic [3:0] p, input logic [2:0] s);
      @(posedge i_clk);
      {i_seq_up, i_seq_down, i_uv_b, i_uv_c, i_seq_slot} <= {p, s};
      @(posedge i_clk);
      {i_seq_up, i_seq_down, i_uv_b, i_uv_c} <= 4'h0;
      settle();
   endtask
   task automatic hw(input logic [1:0] v);
      @(posedge i_clk);
      {i_hw_en2, i_hw_en1} <= v;
      settle();
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Watchdog, far beyond the few hundred cycles needed
   initial begin
      #400000;
      mismatches++;
      summarize();
   end
   // ---------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------
   initial begin
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      #1;
      chk("b rst", b_st, 16'h23e8);
      for (int i = 0; i < 7; i++) begin
         rd(16'h407c + 16'(i), rv[i]);
         wr(16'h407c + 16'(i), 16'hffff);
         rd(16'h407c + 16'(i), mk[i]);
         wr(16'h407c + 16'(i), 16'h0000);
      end
      rd(16'h4090, 16'h0000);
      wr(`RCB_ADDR_A_SLP, 16'hc10d);
      chk("a slot", 16'(o_chan_a_sleep_slot), 16'h0006);
      chk("a mode", 16'(o_chan_a_sleep_opmode), 16'h0001);
      chk("a volt", 16'(o_chan_a_sleep_volt), 16'h000d);
      wr(`RCB_ADDR_B_ON, 16'h2000);
      pulse(4'h8, 3'h1);
      for (int k = 0; k < 32; k++) begin
         wr(`RCB_ADDR_B_ON, 16'h2000 | 16'(k));
         mv = 12'(k < 13 ? 1000 + 50 * k : 1700 + 100 * (k - 13));
         chk("volt", b_st, {4'h8, mv});
      end
      wr(`RCB_ADDR_B_ON, 16'h2000);
      for (int j = 0; j < 3; j++) begin
         wr(`RCB_ADDR_B_SLP, ks[j]);
         pulse(4'h4, kt[j] % 3'h5 + 3'h1);
         chk("early", b_st, 16'h83e8);
         pulse(4'h4, kt[j]);
         chk("sleep", b_st, ke[j]);
         pulse(4'h8, 3'h1);
         chk("wake", b_st, 16'h83e8);
      end
      for (int i = 1; i < 6; i++) begin
         wr(`RCB_ADDR_B_ON, 16'(i << 13));
         wr(`RCB_ADDR_B_SLP, 16'(i << 13));
         pulse(4'h4, 3'((6 - i) % 5 + 1));
         chk("stay", b_st, 16'h83e8);
         pulse(4'h4, 3'(6 - i));
         chk("off", b_st & 16'ha000, 16'h2000);
         pulse(4'h8, 3'(i % 5 + 1));
         chk("idle", b_st & 16'ha000, 16'h2000);
         pulse(4'h8, 3'(i));
         chk("on", b_st, 16'h83e8);
      end
      wr(`RCB_ADDR_C_ON, 16'he000);
      wr(`RCB_ADDR_C_SLP, 16'h211f);
      pulse(4'h8, 3'h1);
      hw(2'h1);
      chk("c in2", c_st & 16'ha000, 16'h2000);
      hw(2'h2);
      chk("c in2", c_st, 16'h83e8);
      wr(`RCB_ADDR_C_ON, 16'hc000);
      chk("c in1", c_st & 16'ha000, 16'h2000);
      hw(2'h1);
      chk("c in1", c_st, 16'h83e8);
      pulse(4'h4, 3'h5);
      chk("c slp", c_st, 16'hcdac);
      wr(`RCB_ADDR_B_ON, 16'ha005);
      wr(`RCB_ADDR_B_SLP, 16'ha01f);
      for (int i = 0; i < 7; i++) begin
         wr(`RCB_ADDR_B_CTL, hc[i]);
         hw(hi[i]);
         chk("hwc", b_st & hm[i], he[i]);
      end
      wr(`RCB_ADDR_B_CTL, 16'h0000);
      wr(`RCB_ADDR_IRQ_EN, 16'h0001);
      pulse(4'h2, 3'h0);
      chk("irq", {15'h0, o_irq}, 16'h0001);
      chk("ignore", b_st & 16'h8000, 16'h8000);
      wr(`RCB_ADDR_IRQ_CLR, 16'h0001);
      chk("irq clr", {15'h0, o_irq}, 16'h0000);
      wr(`RCB_ADDR_B_CTL, 16'h4000);
      pulse(4'h2, 3'h0);
      chk("shut", b_st & 16'h8000, 16'h0000);
      wr(`RCB_ADDR_C_CTL, 16'h8000);
      pulse(4'h1, 3'h0);
      rd(`RCB_ADDR_IRQ_STAT, 16'h0003);
      chk("resets", 16'(rst_pulses), 16'h0001);
      wr(`RCB_ADDR_IRQ_CLR, 16'h0001);
      chk("masked", {15'h0, o_irq}, 16'h0000);
      wr(`RCB_ADDR_IRQ_EN, 16'h0003);
      chk("unmask", {15'h0, o_irq}, 16'h0001);
      wr(`RCB_ADDR_IRQ_CLR, 16'h0003);
      rd(`RCB_ADDR_IRQ_STAT, 16'h0000);
      rd(`RCB_ADDR_IRQ_CLR, 16'h0000);
      summarize();
   end
endmodule // testbench
`default_nettype wire
